// ===== result_format_control_pkg.sv
// Constants for the converter result-format and interrupt-flag block
package result_format_control_pkg;

  // Bus widths
  localparam int DATA_W = 32;
  localparam int ADR_W  = 8;
  localparam int FLAG_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_FORMAT   = 6'h07;
  localparam logic [5:0] IDX_IE_LOW   = 6'h08;
  localparam logic [5:0] IDX_IE_HIGH  = 6'h09;
  localparam logic [5:0] IDX_FLAGS    = 6'h0a;
  localparam logic [5:0] IDX_FLAGMASK = 6'h0c;
  localparam logic [5:0] IDX_ERRSTAT  = 6'h0d;

  // Field positions
  localparam int JUSTIFY_BIT = 7;
  localparam int RES_MSB     = 2;
  localparam int ABORT_BIT   = 7;
  localparam int OVR_BIT     = 6;
  localparam int CMDERR_BIT  = 0;

  // Resolution codes and the result widths they select
  localparam logic [2:0] RES_8BIT  = 3'h0;
  localparam logic [2:0] RES_10BIT = 3'h2;
  localparam logic [2:0] RES_12BIT = 3'h4;
  localparam logic [3:0] BITS_8    = 4'h8;
  localparam logic [3:0] BITS_10   = 4'ha;
  localparam logic [3:0] BITS_12   = 4'hc;
  localparam logic [3:0] BITS_NONE = 4'h0;

  // Reset values
  localparam logic       RST_JUSTIFY = 1'h0;
  localparam logic [2:0] RST_RES     = 3'h0;
  localparam logic [7:0] RST_IE_LOW  = 8'h00;
  localparam logic [7:0] RST_IE_HIGH = 8'h00;
  localparam logic [1:0] RST_MASK    = 2'h0;

  // Complete register state of the block
  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
    logic              justify;
    logic [2:0]        resolution;
    logic [3:0]        res_bits;
    logic [7:0]        ie_low;
    logic [7:0]        ie_high;
    logic              abort_done;
    logic              overrun;
    logic [1:0]        flag_mask;
    logic              cmd_error;
    logic              irq;
  } state_t;

endpackage

// ===== adc_format_irq.sv
// Result-format, conversion interrupt enable and interrupt flag registers
`timescale 1ns/1ps

// Notes on behaviour
// R01: Format writable only when disabled or overridden
// R02: Results unsigned; bit 7 picks justification
// R03: Resolution 000/010/100 gives 8/10/12 bits
// R04: Reserved resolution at start: error, stop
// R05: Format bits 6 to 3 read zero
// R06: Low enable bits 7:1 gate flags 7:1
// R07: Low enable bit 0 gates list end
// R08: High enable byte gates flags 15:8
// R09: Flags clear by writing one or soft reset
// R10: Flags held clear while converter disabled
// R11: Writing zero keeps, writing one never sets
// R12: Abort done set unless low-power abort
// R13: No abort done on strict last-command abort
// R14: Overrun flag set on any flag overrun
// R15: Double buffer: flag set again is overrun
// R16: Single buffer: overrun at first store only
// R17: Soft reset clears severe error, resumes operation
// R18: Interrupt while any enabled flag is set
module adc_format_irq (
  input  wire logic                             CLOCK,
  input  wire logic                             RST,
  input  wire logic                             WB_CYC_I,
  input  wire logic                             WB_STB_I,
  input  wire logic                             WB_WE_I,
  input  wire logic [result_format_control_pkg::ADR_W-1:0]    WB_ADR_I,
  input  wire logic [3:0]                       WB_SEL_I,
  input  wire logic [result_format_control_pkg::DATA_W-1:0]   WB_DAT_I,
  output logic      [result_format_control_pkg::DATA_W-1:0]   WB_DAT_O,
  output logic                                  WB_ACK_O,
  input  wire logic                             CONV_ENABLE,
  input  wire logic                             ACCESS_OVERRIDE,
  input  wire logic                             SOFT_RESET,
  input  wire logic                             CONV_START,
  input  wire logic                             ABORT_DONE,
  input  wire logic                             ABORT_LOW_POWER,
  input  wire logic                             LAST_CMD_ACTIVE,
  input  wire logic                             STRICT_ABORT,
  input  wire logic                             BUFFER_MODE,
  input  wire logic                             FIRST_RESULT_STORE,
  input  wire logic [result_format_control_pkg::FLAG_W-1:0]   FLAG_SET,
  input  wire logic [result_format_control_pkg::FLAG_W-1:0]   FLAG_STATE,
  output logic                                  RESULT_JUSTIFY,
  output logic      [2:0]                       RESULT_RESOLUTION,
  output logic      [3:0]                       RESULT_BITS,
  output logic                                  COMMAND_ERROR_FLAG,
  output logic                                  IRQ
);
  import result_format_control_pkg::*;

  state_t s_q;
  state_t s_d;

  logic       req;
  logic       wr;
  logic [5:0] idx;
  logic       fmt_open;
  logic       abort_set;
  logic       ovr_dbl;
  logic       ovr_sgl;
  logic       ovr_set;
  logic       res_bad;
  logic       clr_abort;
  logic       clr_ovr;

  // Per-register write strobes, each qualified by the ack edge
  logic       wr_fmt;
  logic       wr_ie_low;
  logic       wr_ie_high;
  logic       wr_flags;
  logic       wr_mask;

  // Enable values as they will stand after this edge
  logic [7:0] ie_low_nx;
  logic [7:0] ie_high_nx;

  // Per-flag views and their reductions, built in the gating section below
  logic [FLAG_W-1:0] flag_en;
  logic [FLAG_W-1:0] flag_hit;
  logic [FLAG_W-1:0] flag_again;
  logic              any_hit;
  logic              any_again;
  logic              any_pending;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Write takes effect on the edge where the master sees ack
  // Only byte lane 0 carries register data; other lanes are acked and dropped
  assign req = WB_CYC_I & WB_STB_I;
  assign wr  = req & WB_WE_I & s_q.ack & WB_SEL_I[0];
  assign idx = WB_ADR_I[ADR_W-1:2];

  // One strobe per register keeps the next-state logic readable; unmapped
  // indices match none of them, so their writes vanish
  assign wr_fmt     = wr && (idx == IDX_FORMAT);
  assign wr_ie_low  = wr && (idx == IDX_IE_LOW);
  assign wr_ie_high = wr && (idx == IDX_IE_HIGH);
  assign wr_flags   = wr && (idx == IDX_FLAGS);
  assign wr_mask    = wr && (idx == IDX_FLAGMASK);

  // Enable registers have no lock; software may change them at any time,
  // and the interrupt line follows on the same edge
  assign ie_low_nx  = wr_ie_low ? WB_DAT_I[7:0] : s_q.ie_low;   // [R06] [R07]
  assign ie_high_nx = wr_ie_high ? WB_DAT_I[7:0] : s_q.ie_high; // [R08]

  // Format fields are locked while converting unless overridden
  // A refused write is still acked, so software sees no bus error
  assign fmt_open = ~CONV_ENABLE | ACCESS_OVERRIDE; // [R01]

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification

  // Hardware aborts for low-power entry are silent; so is an abort that
  // arrives during the last command of a list in strict mode. Both
  // qualifiers are levels sampled on the same edge as the abort pulse.
  assign abort_set = ABORT_DONE & ~ABORT_LOW_POWER // [R12]
                   & ~(LAST_CMD_ACTIVE & STRICT_ABORT); // [R13]

  // Double buffer: any flag re-set while still pending
  assign ovr_dbl = BUFFER_MODE & any_again; // [R15]
  // Single buffer: list-end flag ignored, checked at first store
  assign ovr_sgl = ~BUFFER_MODE & FIRST_RESULT_STORE & any_pending; // [R16]
  // Either mode feeds the one overrun flag
  assign ovr_set = ovr_dbl | ovr_sgl; // [R14]

  // Only the three documented codes are legal; every other code is a
  // severe error at the next conversion start. The check reads the stored
  // code, which is the one the converter would use.
  function automatic logic reserved_code(input logic [2:0] r);
    logic bad;
    bad = 1'b1;
    unique case (r)
      RES_8BIT:  bad = 1'b0;
      RES_10BIT: bad = 1'b0;
      RES_12BIT: bad = 1'b0;
      default:   bad = 1'b1;
    endcase
    return bad;
  endfunction

  assign res_bad = reserved_code(s_q.resolution); // [R04]

  // Ones clear, zeros leave flags alone; a write never sets a flag
  assign clr_abort = wr_flags & WB_DAT_I[ABORT_BIT]; // [R09] [R11]
  assign clr_ovr   = wr_flags & WB_DAT_I[OVR_BIT];   // [R09] [R11]

  ////////////////////////////////////////////////////////////////////////////
  // Per-flag gating and overrun detection

  // Enable vector in flag order: high byte, low bits 7:1, list end in bit 0
  assign flag_en = {ie_high_nx, ie_low_nx};

  // A flag reaches the interrupt line only through its own enable bit; the
  // enable about to be stored is used, so IRQ follows an enable write that
  // lands on the same edge. A set request on a flag still pending is an
  // overrun candidate. The list-end flag counts here, which is why only the
  // double-buffer path uses this vector.
  for (genvar g = 0; g < FLAG_W; g++)
  begin : g_flag
    assign flag_hit[g]   = FLAG_STATE[g] & flag_en[g]; // [R06] [R07] [R08]
    assign flag_again[g] = FLAG_SET[g] & FLAG_STATE[g]; // [R15]
  end

  // Reductions; single-buffer overrun looks at conversion flags only
  assign any_hit     = |flag_hit;               // [R18]
  assign any_again   = |flag_again;             // [R15]
  assign any_pending = |FLAG_STATE[FLAG_W-1:1]; // [R16]

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  // Unmapped addresses read zero and still ack; the upper lanes always
  // read zero since every register is one byte wide
  function automatic logic [DATA_W-1:0] read_word(input state_t s, input logic [5:0] i);
    logic [DATA_W-1:0] v;
    v = '0;
    unique case (i)
      IDX_FORMAT:
      begin
        v[JUSTIFY_BIT]   = s.justify;
        v[RES_MSB:0]     = s.resolution; // [R05]
      end
      IDX_IE_LOW:
      begin
        v[7:0] = s.ie_low;
      end
      IDX_IE_HIGH:
      begin
        v[7:0] = s.ie_high;
      end
      IDX_FLAGS:
      begin
        v[ABORT_BIT] = s.abort_done;
        v[OVR_BIT]   = s.overrun;
      end
      IDX_FLAGMASK:
      begin
        v[ABORT_BIT] = s.flag_mask[1];
        v[OVR_BIT]   = s.flag_mask[0];
      end
      IDX_ERRSTAT:
      begin
        v[CMDERR_BIT] = s.cmd_error;
      end
      default:      v = '0;
    endcase
    return v;
  endfunction

  // Result width decode; reserved codes give zero, so a consumer that
  // ignores the error flag still cannot pick a width of its own
  function automatic logic [3:0] width_of(input logic [2:0] r);
    logic [3:0] w;
    w = BITS_NONE;
    if (r == RES_8BIT)
    begin
      w = BITS_8;
    end
    else if (r == RES_10BIT)
    begin
      w = BITS_10;
    end
    else if (r == RES_12BIT)
    begin
      w = BITS_12;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d = s_q;
    // Everything holds by default; each group below overrides only its own
    // fields, and a later group wins over an earlier one

    // Single-cycle ack, dropped the cycle after it is given; read data is
    // captured with it, and it holds after ack falls until the next access is acked
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack)
    begin
      s_d.rdata = read_word(s_q, idx);
    end

    // Format register; reserved bits are never stored, so they read zero
    if (wr_fmt && fmt_open) // [R01]
    begin
      s_d.justify    = WB_DAT_I[JUSTIFY_BIT]; // [R02]
      s_d.resolution = WB_DAT_I[RES_MSB:0];
    end
    // Width follows the stored code, so it never lags the format register
    s_d.res_bits = width_of(s_d.resolution); // [R03]

    // Enable registers take the values prepared above; the same values feed
    // the interrupt gating, so the two cannot disagree
    s_d.ie_low  = ie_low_nx;
    s_d.ie_high = ie_high_nx;

    // Mask of the block's own flags, in the same bit places as the flags
    if (wr_mask)
    begin
      s_d.flag_mask = {WB_DAT_I[ABORT_BIT], WB_DAT_I[OVR_BIT]};
    end

    // Sticky abort-done flag: a set in the clearing cycle wins
    if (abort_set)
    begin
      s_d.abort_done = 1'b1; // [R12] [R13]
    end
    else if (clr_abort || SOFT_RESET)
    begin
      s_d.abort_done = 1'b0; // [R09] [R11]
    end

    // Sticky overrun flag, same priority as the abort-done flag
    if (ovr_set)
    begin
      s_d.overrun = 1'b1; // [R14]
    end
    else if (clr_ovr || SOFT_RESET)
    begin
      s_d.overrun = 1'b0; // [R09] [R11]
    end

    // Severe error stays until soft reset or converter disable; a fresh start can set it again,
    // and that set beats a soft reset in the same cycle
    if (CONV_START & res_bad)
    begin
      s_d.cmd_error = 1'b1; // [R04]
    end
    else if (SOFT_RESET)
    begin
      s_d.cmd_error = 1'b0; // [R17]
    end

    // Disabled converter forces every flag low; this beats any set
    if (!CONV_ENABLE)
    begin
      s_d.abort_done = 1'b0; // [R10]
      s_d.overrun    = 1'b0; // [R10]
      s_d.cmd_error  = 1'b0; // [R10]
    end

    // Conversion flags through their enables, own flags through the mask;
    // built from next values so IRQ moves on the same edge as the flags
    s_d.irq = any_hit                                // [R06] [R07] [R08] [R18]
            | (s_d.abort_done & s_d.flag_mask[1])
            | (s_d.overrun & s_d.flag_mask[0]);      // [R18]
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset loads the idle values; the width output starts at
  // eight bits to match resolution code 000
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      s_q            <= '0;
      s_q.justify    <= RST_JUSTIFY;
      s_q.resolution <= RST_RES;
      s_q.res_bits   <= BITS_8;
      s_q.ie_low     <= RST_IE_LOW;
      s_q.ie_high    <= RST_IE_HIGH;
      s_q.flag_mask  <= RST_MASK;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  // No output is decoded combinationally, so none can glitch

  assign WB_ACK_O           = s_q.ack;
  assign WB_DAT_O           = s_q.rdata;
  assign RESULT_JUSTIFY     = s_q.justify;
  assign RESULT_RESOLUTION  = s_q.resolution;
  assign RESULT_BITS        = s_q.res_bits;
  assign COMMAND_ERROR_FLAG = s_q.cmd_error; // [R04]
  assign IRQ                = s_q.irq;

endmodule

// ===== adc_format_irq_assertions.sv
// Port assertions for the format and flag block
`timescale 1ns/1ps
module adc_format_irq_assertions (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        CONV_ENABLE,
  input wire logic        ACCESS_OVERRIDE,
  input wire logic        SOFT_RESET,
  input wire logic        CONV_START,
  input wire logic        RESULT_JUSTIFY,
  input wire logic [2:0]  RESULT_RESOLUTION,
  input wire logic        COMMAND_ERROR_FLAG
);
  import result_format_control_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////
  // Format access at its ack edge; lock is judged there, where the write lands
  wire fmt  = WB_ACK_O && WB_STB_I && WB_ADR_I[7:2] == IDX_FORMAT;
  wire wr   = fmt && WB_WE_I && WB_SEL_I[0];
  wire lock = CONV_ENABLE && !ACCESS_OVERRIDE;
  wire bad  = !(RESULT_RESOLUTION inside {RES_8BIT, RES_10BIT, RES_12BIT});
  ////////////////////////////////////////
  AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  AST_FMT_LOCK: assert property (wr && lock |=> $stable(RESULT_RESOLUTION))
    else $error("locked write landed");
  AST_FMT_WR: assert property (wr && !lock |=> RESULT_JUSTIFY == $past(WB_DAT_I[7])
    && RESULT_RESOLUTION == $past(WB_DAT_I[2:0])) else $error("format write lost");
  AST_FMT_RO: assert property (fmt && !WB_WE_I |-> WB_DAT_O[6:3] == 4'h0)
    else $error("format 6:3 not zero");
  AST_ERR_SET: assert property (CONV_ENABLE && CONV_START && bad |=> COMMAND_ERROR_FLAG)
    else $error("reserved code not flagged");
  AST_ERR_HOLD: assert property (COMMAND_ERROR_FLAG && CONV_ENABLE && !SOFT_RESET
    |=> COMMAND_ERROR_FLAG) else $error("error dropped");
  AST_ERR_CLR: assert property (SOFT_RESET && !CONV_START |=> !COMMAND_ERROR_FLAG)
    else $error("soft reset kept error");
  AST_ERR_OFF: assert property (!CONV_ENABLE |=> !COMMAND_ERROR_FLAG)
    else $error("error while disabled");
  // Main scenarios reached
  cover property (wr && lock);
  cover property (CONV_START && bad && CONV_ENABLE);
  cover property (SOFT_RESET && COMMAND_ERROR_FLAG);
endmodule
bind adc_format_irq adc_format_irq_assertions u_adc_format_irq_assertions (.CLOCK, .RST,
  .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .CONV_ENABLE,
  .ACCESS_OVERRIDE, .SOFT_RESET, .CONV_START, .RESULT_JUSTIFY, .RESULT_RESOLUTION,
  .COMMAND_ERROR_FLAG);

// ===== test_adc_format_irq.sv
// Random and corner tests of the format and flag block
`timescale 1ns/1ps
module test_adc_format_irq;
  import result_format_control_pkg::*;
  logic CLOCK = 1'b0, RST = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
  logic CONV_ENABLE = 1'b0, ACCESS_OVERRIDE = 1'b0, SOFT_RESET = 1'b0, CONV_START = 1'b0;
  logic ABORT_DONE = 1'b0, ABORT_LOW_POWER = 1'b0, LAST_CMD_ACTIVE = 1'b0, STRICT_ABORT = 1'b0;
  logic BUFFER_MODE = 1'b0, FIRST_RESULT_STORE = 1'b0, WB_ACK_O, RESULT_JUSTIFY;
  logic COMMAND_ERROR_FLAG, IRQ, ov;
  logic [2:0] RESULT_RESOLUTION;
  logic [3:0] WB_SEL_I = 4'h1, RESULT_BITS;
  logic [7:0] WB_ADR_I = 8'h00, q, f = 8'h00;
  logic [15:0] FLAG_SET = 16'h0, FLAG_STATE = 16'h0, s, t;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, seed = 32'hb148fa79, r;
  int miscompares = 0, checks = 0;
  adc_format_irq u_adc_format_irq (.*);
  // Free-running 100 MHz clock
  always #5 CLOCK = ~CLOCK;
  ////////////////////////////////////////
  // Xorshift source; fixed seed keeps runs repeatable
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Result width that a resolution code must give
  function logic [3:0] width(input logic [2:0] c);
    return c == 3'h0 ? BITS_8 : c == 3'h2 ? BITS_10 : c == 3'h4 ? BITS_12 : BITS_NONE;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  // Classic cycle held until ack; a bounded wait so a dead slave cannot hang us
  task wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int n;
    @(posedge CLOCK);
    {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'b11, w};
    WB_ADR_I <= {i, 2'h0};
    WB_DAT_I <= {24'h0, d};
    n = 0;
    do @(posedge CLOCK) n++; while (WB_ACK_O !== 1'b1 && n < 50);
    chk(n < 50, 1'b1, "ack");
    q = WB_DAT_O[7:0];
    {WB_CYC_I, WB_STB_I} <= 2'b00;
  endtask
  task rd(input logic [5:0] i, input logic [7:0] x, input string what);
    wb(1'b0, i, 8'h00);
    chk(q, x, what);
  endtask
  task results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog: the tests need fewer than a thousand cycles, this allows some thirty thousand
  initial
  begin
    #300000;
    miscompares++;
    results();
  end
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    step(6);
    RST <= 1'b0;
    for (int i = 7; i < 12; i++)
      rd(i == 11 ? 6'h3f : 6'(i), 8'h00, "reset or unmapped");
    $display("reset test done");
    // Every code written locked and unlocked, then a start with the stored code
    for (int i = 0; i < 32; i++)
    begin
      r = rnd();
      {ACCESS_OVERRIDE, CONV_ENABLE} <= 2'(i >> 3);
      wb(1'b1, IDX_FORMAT, {r[7:3], 3'(i)});
      if (!i[3] || i[4])
        f = {r[7], 4'h0, 3'(i)};
      rd(IDX_FORMAT, f, "format");
      chk({RESULT_JUSTIFY, RESULT_BITS}, {f[7], width(f[2:0])}, "justify width");
      {CONV_ENABLE, CONV_START} <= 2'b11;
      step(1);
      CONV_START <= 1'b0;
      step(1);
      chk(COMMAND_ERROR_FLAG, width(f[2:0]) == 4'h0, "severe error");
      rd(IDX_ERRSTAT, {7'h0, width(f[2:0]) == 4'h0}, "error status");
      SOFT_RESET <= 1'b1;
      step(1);
      SOFT_RESET <= 1'b0;
      step(1);
      chk(COMMAND_ERROR_FLAG, 1'b0, "error cleared");
    end
    $display("format test done");
    // Abort under each qualifier, then zero, one and clearing writes
    for (int i = 0; i < 8; i++)
    begin
      f = (!i[2] && !(i[1] && i[0])) ? 8'h80 : 8'h00;
      {ABORT_DONE, ABORT_LOW_POWER, LAST_CMD_ACTIVE, STRICT_ABORT} <= {1'b1, 3'(i)};
      step(1);
      ABORT_DONE <= 1'b0;
      rd(IDX_FLAGS, f, "abort done");
      wb(1'b1, IDX_FLAGS, 8'h40);
      rd(IDX_FLAGS, f, "zero write keeps");
      wb(1'b1, IDX_FLAGS, 8'hc0);
      rd(IDX_FLAGS, 8'h00, "one write clears");
    end
    // Overrun in both buffer modes; list-end bit forced on some passes
    for (int i = 0; i < 16; i++)
    begin
      r = rnd();
      s = i[3] ? 16'h1 : 16'h1 << r[3:0];
      t = i[2] ? s : 16'h1 << r[7:4];
      ov = i[0] ? |(s & t) : i[1] && |t[15:1];
      {BUFFER_MODE, FIRST_RESULT_STORE, FLAG_SET, FLAG_STATE} <= {i[0], i[1], s, t};
      step(1);
      {FIRST_RESULT_STORE, FLAG_SET} <= 17'h0;
      rd(IDX_FLAGS, {1'b0, ov, 6'h00}, "overrun");
      SOFT_RESET <= 1'b1;
      step(1);
      SOFT_RESET <= 1'b0;
      rd(IDX_FLAGS, 8'h00, "soft reset clears");
    end
    $display("flag test done");
    // Random enables against one live flag; the first passes use the list-end bit
    for (int i = 0; i < 16; i++)
    begin
      r = rnd();
      s = i < 3 ? 16'h1 : 16'h1 << r[19:16];
      wb(1'b1, IDX_IE_LOW, r[7:0]);
      wb(1'b1, IDX_IE_HIGH, r[15:8]);
      FLAG_STATE <= s;
      step(2);
      chk(IRQ, |(r[15:0] & s), "irq");
    end
    rd(IDX_IE_HIGH, r[15:8], "enable high");
    FLAG_STATE <= 16'h0;
    wb(1'b1, IDX_FLAGMASK, 8'h80);
    rd(IDX_FLAGMASK, 8'h80, "flag mask");
    {ABORT_DONE, ABORT_LOW_POWER, LAST_CMD_ACTIVE, STRICT_ABORT} <= 4'h8;
    step(1);
    ABORT_DONE <= 1'b0;
    step(1);
    chk(IRQ, 1'b1, "flag irq");
    CONV_ENABLE <= 1'b0;
    step(2);
    chk(IRQ, 1'b0, "irq off");
    rd(IDX_FLAGS, 8'h00, "disabled flags");
    $display("irq test done");
    results();
  end
endmodule
